// ===== common/thsg_pkg.sv
// Shared constants, types and functions of the two-hand safety gating block
package thsg_pkg;
  localparam int unsigned CLK_KHZ      = 25000;
  localparam int unsigned SYNC_TIME_MS = 500;
  localparam int unsigned SYNC_CYC     = SYNC_TIME_MS * CLK_KHZ;
  localparam int unsigned DISC_TIME_MS = 50;
  localparam int unsigned DISC_CYC     = DISC_TIME_MS * CLK_KHZ;
  localparam int unsigned MSG_TMO_MS   = 100;
  localparam int unsigned MSG_TMO_CYC  = MSG_TMO_MS * CLK_KHZ;
  localparam int TMR_W   = 24;
  localparam int DISC_W  = 21;
  localparam int TMO_W   = 22;
  localparam int SECT_N  = 2;
  localparam int PARAM_W = 16;
  localparam int DATA_W  = 8;
  localparam int ID_W    = 8;
  localparam int STAMP_W = 8;
  localparam int CRC_W   = 8;
  localparam int MSG_W   = ID_W + STAMP_W + DATA_W;
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'hff;
  localparam logic [ID_W-1:0]  PEER_ID_DEF = 8'h5a; // Arbitrary value
  localparam int PERMIT_BIT = 0;
  // Pin positions in the synchronised input vector
  localparam int PIN_A_NO    = 0;
  localparam int PIN_A_NC    = 1;
  localparam int PIN_B_NO    = 2;
  localparam int PIN_B_NC    = 3;
  localparam int PIN_ESTOP_N = 4;
  localparam int PIN_GND_F   = 5;
  localparam int PIN_INT_F   = 6;
  localparam int PIN_DOOR0   = 7;
  localparam int PIN_CMD0    = PIN_DOOR0 + SECT_N;
  localparam int PIN_W       = PIN_CMD0 + SECT_N;

  typedef enum logic [3:0] {
    TH_IDLE = 4'h1,
    TH_WAIT = 4'h2,
    TH_RUN  = 4'h4,
    TH_LOCK = 4'h8
  } thsg_state_t;

  // Contact pair reads as pressed: NO closed, NC open
  function automatic logic thsg_pressed(input logic no, input logic nc);
    return no & ~nc;
  endfunction

  // Contact pair in an implausible (both equal) state
  function automatic logic thsg_implausible(input logic no, input logic nc);
    return ~(no ^ nc);
  endfunction

  // Bitwise check code over identity, stamp and data
  function automatic logic [CRC_W-1:0] thsg_crc8(input logic [MSG_W-1:0] d);
    logic [CRC_W-1:0] c;
    c = CRC_INIT;
    for (int i = MSG_W - 1; i >= 0; i--) begin
      c = (c[CRC_W-1] ^ d[i]) ? ({c[CRC_W-2:0], 1'b0} ^ CRC_POLY) : {c[CRC_W-2:0], 1'b0};
    end
    return c;
  endfunction
endpackage

// ===== common/thsg_msg_if.sv
// Safety message carrier between the gating core and the message checker
`timescale 1ns/100ps
`default_nettype none
interface thsg_msg_if;
  import thsg_pkg::*;
  logic                valid;
  logic [DATA_W-1:0]   data;
  logic [DATA_W-1:0]   inv;
  logic [CRC_W-1:0]    crc;
  logic [ID_W-1:0]     src_id;
  logic [STAMP_W-1:0]  stamp;
  logic                fault;
  logic                permit;
  modport src (output valid, data, inv, crc, src_id, stamp, input fault, permit);
  modport chk (input valid, data, inv, crc, src_id, stamp, output fault, permit);
endinterface
`default_nettype wire

// ===== core/thsg_msg_check.sv
// Safety network message checker: inverted copy, check code, identity, time order
`timescale 1ns/100ps
`default_nettype none
module thsg_msg_check #(
  parameter logic [thsg_pkg::ID_W-1:0] PEER_ID = thsg_pkg::PEER_ID_DEF,
  parameter int unsigned     TMO_CYCLES  = thsg_pkg::MSG_TMO_CYC
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  thsg_msg_if.chk   msg
);
  import thsg_pkg::*;

  logic               fault_reg;
  logic               permit_reg;
  logic               have_reg;
  logic [STAMP_W-1:0] stamp_reg;
  logic [TMO_W-1:0]   age_reg;

  // Per-message checks
  wire inv_ok   = (msg.inv == ~msg.data);
  wire crc_ok   = (msg.crc == thsg_crc8({msg.src_id, msg.stamp, msg.data}));
  wire id_ok    = (msg.src_id == PEER_ID);
  wire order_ok = ~have_reg | (msg.stamp == STAMP_W'(stamp_reg + 1'b1));
  wire late     = (age_reg == TMO_W'(TMO_CYCLES - 1));
  wire good     = msg.valid & inv_ok & crc_ok & id_ok & order_ok;
  wire bad      = (msg.valid & ~good) | late;

  // Sticky fault, last good permit and arrival age
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      fault_reg  <= 1'b0;
      permit_reg <= 1'b0;
      have_reg   <= 1'b0;
      stamp_reg  <= '0;
      age_reg    <= '0;
    end else begin
      fault_reg  <= fault_reg | bad;
      permit_reg <= (bad | fault_reg) ? 1'b0 : (good ? msg.data[PERMIT_BIT] : permit_reg);
      have_reg   <= have_reg | good;
      stamp_reg  <= good ? msg.stamp : stamp_reg;
      age_reg    <= (good | late) ? '0 : TMO_W'(age_reg + 1'b1);
    end
  end

  assign msg.fault  = fault_reg;
  assign msg.permit = permit_reg;

  // Checks on message rejection
  a_inv_reject: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (msg.valid && !inv_ok) |=> (fault_reg && !permit_reg)) else $error("inverted copy mismatch accepted");
  a_crc_reject: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (msg.valid && !crc_ok) |=> fault_reg) else $error("bad check code accepted");
  a_id_reject: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (msg.valid && !id_ok) |=> (fault_reg && !permit_reg)) else $error("foreign identity accepted");
  a_stamp_order: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (msg.valid && have_reg && msg.stamp != STAMP_W'(stamp_reg + 1'b1)) |=> fault_reg)
    else $error("out of order message accepted");
  c_good_msg: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) good ##1 permit_reg);
endmodule
`default_nettype wire

// ===== core/thsg_gating.sv
// Two-hand start and operate gating core with wiring, parameter and network checks
//
// Overview of operation
// - Two-hand output only while both push inputs are pressed.
// - Two-hand output drops once either or both push inputs release.
// - After a drop, restart needs both inputs seen released together.
// - Second press must follow the first within 0.5 s.
// - Operate output needs external command and internal safety confirmation.
// - Emergency stop forces every section output off.
// - Open door holds only its own section off.
// - Wiring and internal faults are detected and block operation.
// - Operate outputs stay off until parameter transfer is confirmed.
// - Messages carry data plus inverted copy; responses are checked.
// - Messages carry a check code; mismatches are rejected.
// - Messages carry sender identity; wrong identity is discarded.
// - Time stamps catch reordered or late messages as a fault.
`timescale 1ns/100ps
`default_nettype none
module thsg_gating #(
  parameter int unsigned           SYNC_CYCLES = thsg_pkg::SYNC_CYC,
  parameter int unsigned           DISC_CYCLES = thsg_pkg::DISC_CYC,
  parameter int unsigned           TMO_CYCLES  = thsg_pkg::MSG_TMO_CYC,
  parameter logic [thsg_pkg::ID_W-1:0] PEER_ID = thsg_pkg::PEER_ID_DEF
) (
  input  wire logic                           ref_clk_i,
  input  wire logic                           reset_n_i,
  input  wire logic                           push_a_no_i,
  input  wire logic                           push_a_nc_i,
  input  wire logic                           push_b_no_i,
  input  wire logic                           push_b_nc_i,
  input  wire logic                           estop_n_i,
  input  wire logic [thsg_pkg::SECT_N-1:0]    door_open_i,
  input  wire logic [thsg_pkg::SECT_N-1:0]    operate_cmd_i,
  input  wire logic                           ground_fault_i,
  input  wire logic                           internal_fault_i,
  input  wire logic                           param_load_i,
  input  wire logic [thsg_pkg::PARAM_W-1:0]   param_word_i,
  input  wire logic                           param_echo_valid_i,
  input  wire logic [thsg_pkg::PARAM_W-1:0]   param_echo_i,
  input  wire logic                           msg_valid_i,
  input  wire logic [thsg_pkg::DATA_W-1:0]    msg_data_i,
  input  wire logic [thsg_pkg::DATA_W-1:0]    msg_inv_i,
  input  wire logic [thsg_pkg::CRC_W-1:0]     msg_crc_i,
  input  wire logic [thsg_pkg::ID_W-1:0]      msg_src_id_i,
  input  wire logic [thsg_pkg::STAMP_W-1:0]   msg_stamp_i,
  output logic      [thsg_pkg::SECT_N-1:0]    operate_o,
  output logic                                two_hand_o,
  output logic                                wiring_fault_o,
  output logic                                param_ok_o,
  output logic                                comm_fault_o
);
  import thsg_pkg::*;

  logic [PIN_W-1:0]   sync1_reg;
  logic [PIN_W-1:0]   sync2_reg;
  thsg_state_t        state_reg;
  thsg_state_t        state_next;
  logic [TMR_W-1:0]   timer_reg;
  logic [DISC_W-1:0]  disc_a_reg;
  logic [DISC_W-1:0]  disc_b_reg;
  logic               wfault_reg;
  logic [PARAM_W-1:0] pword_reg;
  logic               pok_reg;
  logic [SECT_N-1:0]  operate_reg;
  logic               th_reg;

  thsg_msg_if msg ();

  // Two-stage synchroniser for every pin input
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {operate_cmd_i, door_open_i, internal_fault_i, ground_fault_i, estop_n_i,
                    push_b_nc_i, push_b_no_i, push_a_nc_i, push_a_no_i};
      sync2_reg <= sync1_reg;
    end
  end

  // Decoded push, stop, door and command levels
  wire               a_pr     = thsg_pressed(sync2_reg[PIN_A_NO], sync2_reg[PIN_A_NC]);
  wire               b_pr     = thsg_pressed(sync2_reg[PIN_B_NO], sync2_reg[PIN_B_NC]);
  wire               a_odd    = thsg_implausible(sync2_reg[PIN_A_NO], sync2_reg[PIN_A_NC]);
  wire               b_odd    = thsg_implausible(sync2_reg[PIN_B_NO], sync2_reg[PIN_B_NC]);
  wire               both_pr  = a_pr & b_pr;
  wire               none_pr  = ~a_pr & ~b_pr;
  wire               estop_ok = sync2_reg[PIN_ESTOP_N];
  wire [SECT_N-1:0]  door_op  = sync2_reg[PIN_DOOR0 +: SECT_N];
  wire [SECT_N-1:0]  cmd      = sync2_reg[PIN_CMD0 +: SECT_N];
  wire               tmo      = (timer_reg == TMR_W'(SYNC_CYCLES - 1));
  wire               disc_hit = (disc_a_reg == DISC_W'(DISC_CYCLES - 1)) |
                                (disc_b_reg == DISC_W'(DISC_CYCLES - 1));
  wire               fault_any = wfault_reg | disc_hit | sync2_reg[PIN_GND_F] | sync2_reg[PIN_INT_F];

  // Two-hand sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TH_IDLE: begin
        if (both_pr) begin
          state_next = TH_RUN;
        end else if (!none_pr) begin
          state_next = TH_WAIT;
        end
      end
      TH_WAIT: begin
        if (both_pr && !tmo) begin
          state_next = TH_RUN;
        end else if (tmo) begin
          state_next = TH_LOCK;
        end else if (none_pr) begin
          state_next = TH_IDLE;
        end
      end
      TH_RUN: begin
        if (!both_pr) begin
          state_next = TH_LOCK;
        end
      end
      TH_LOCK: begin
        if (none_pr) begin
          state_next = TH_IDLE;
        end
      end
    endcase
  end

  // Sequencer state and sync window timer
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= TH_LOCK;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= (state_reg == TH_WAIT) ? TMR_W'(timer_reg + 1'b1) : '0;
    end
  end

  // Contact plausibility counters and sticky wiring fault
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      disc_a_reg <= '0;
      disc_b_reg <= '0;
      wfault_reg <= 1'b0;
    end else begin
      disc_a_reg <= (a_odd && !disc_hit) ? DISC_W'(disc_a_reg + 1'b1) : '0;
      disc_b_reg <= (b_odd && !disc_hit) ? DISC_W'(disc_b_reg + 1'b1) : '0;
      wfault_reg <= fault_any;
    end
  end

  // Parameter transfer confirmation, match wins over a fresh load
  wire [PARAM_W-1:0] pword_cur = param_load_i ? param_word_i : pword_reg;
  wire               pmatch    = param_echo_valid_i & (param_echo_i == pword_cur);

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pword_reg <= '0;
      pok_reg   <= 1'b0;
    end else begin
      pword_reg <= pword_cur;
      pok_reg   <= pmatch | (pok_reg & ~param_load_i);
    end
  end

  // Network message checker
  assign msg.valid  = msg_valid_i;
  assign msg.data   = msg_data_i;
  assign msg.inv    = msg_inv_i;
  assign msg.crc    = msg_crc_i;
  assign msg.src_id = msg_src_id_i;
  assign msg.stamp  = msg_stamp_i;

  thsg_msg_check #(
    .PEER_ID    (PEER_ID),
    .TMO_CYCLES (TMO_CYCLES)
  ) u_msg_check (
    .ref_clk_i  (ref_clk_i),
    .reset_n_i  (reset_n_i),
    .msg        (msg)
  );

  // Operate gating per section
  wire               th_ok   = (state_reg == TH_RUN) & both_pr;
  wire               safe_ok = th_ok & estop_ok & ~fault_any & pok_reg & msg.permit & ~msg.fault;
  wire [SECT_N-1:0]  op_next = {SECT_N{safe_ok}} & cmd & ~door_op;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      operate_reg <= '0;
      th_reg      <= 1'b0;
    end else begin
      operate_reg <= op_next;
      th_reg      <= th_ok;
    end
  end

  assign operate_o      = operate_reg;
  assign two_hand_o     = th_reg;
  assign wiring_fault_o = wfault_reg;
  assign param_ok_o     = pok_reg;
  assign comm_fault_o   = msg.fault;

  // Checks on the gating behaviour
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_two_hand_both: assert property (two_hand_o |-> $past(a_pr && b_pr))
    else $error("two-hand output with a single input");
  a_release_drop: assert property ((!a_pr || !b_pr) |=> (!two_hand_o && operate_o == '0))
    else $error("output held after release");
  a_restart_lock: assert property ((state_reg == TH_LOCK && !none_pr) |=> state_reg != TH_RUN)
    else $error("restart without full release");
  a_sync_expiry: assert property ((state_reg == TH_WAIT && tmo) |=> state_reg == TH_LOCK ##1 !two_hand_o)
    else $error("late second press accepted");
  a_cmd_gate: assert property ((operate_o[0] |-> $past(cmd[0] && msg.permit)) and
                               (operate_o[1] |-> $past(cmd[1] && msg.permit)))
    else $error("operate without command and confirmation");
  a_estop_all: assert property (!estop_ok |=> operate_o == '0)
    else $error("emergency stop did not clear outputs");
  a_door_local: assert property ((door_op[0] && !door_op[1] && op_next[1]) |=> (!operate_o[0] && operate_o[1]))
    else $error("door gating not section local");
  a_fault_block: assert property ($rose(wfault_reg) |-> operate_o == '0 ##1 (operate_o == '0)[*2])
    else $error("operate despite wiring fault");
  a_param_gate: assert property (!pok_reg |=> operate_o == '0)
    else $error("operate before parameter confirmation");
  a_comm_gate: assert property (msg.fault |=> operate_o == '0)
    else $error("operate despite communication fault");

  c_sync_start: cover property (state_reg == TH_WAIT ##1 state_reg == TH_RUN ##1 two_hand_o);
  c_sync_lock:  cover property (state_reg == TH_WAIT ##1 state_reg == TH_LOCK);
  c_operate:    cover property (operate_o == '1);
  c_door_part:  cover property (operate_o[1] && door_op[0]);
endmodule
`default_nettype wire

// ===== tb/thsg_far_side.sv
// Far-side model: push buttons, guards, automation command and safety message sender
`timescale 1ns/100ps
`default_nettype none
module thsg_far_side (
  input  wire logic                           ref_clk_i,
  output var  logic                           a_no_o,
  output var  logic                           a_nc_o,
  output var  logic                           b_no_o,
  output var  logic                           b_nc_o,
  output var  logic                           estop_n_o,
  output var  logic [thsg_pkg::SECT_N-1:0]    door_o,
  output var  logic [thsg_pkg::SECT_N-1:0]    cmd_o,
  output var  logic                           gnd_o,
  output var  logic                           intf_o,
  output var  logic                           valid_o,
  output var  logic [thsg_pkg::DATA_W-1:0]    data_o,
  output var  logic [thsg_pkg::DATA_W-1:0]    inv_o,
  output var  logic [thsg_pkg::CRC_W-1:0]     crc_o,
  output var  logic [thsg_pkg::ID_W-1:0]      id_o,
  output var  logic [thsg_pkg::STAMP_W-1:0]   stamp_o
);
  import thsg_pkg::*;
  logic               permit;
  int                 err_mode;
  int                 gap;
  logic [STAMP_W-1:0] seq;
  logic [DATA_W-1:0]  d;
  logic [ID_W-1:0]    id;
  logic [STAMP_W-1:0] st;
  logic [CRC_W-1:0]   c;

  // Own check code: poly 0x07, init 0xff, MSB first
  function automatic logic [CRC_W-1:0] code_of(input logic [MSG_W-1:0] m);
    logic [CRC_W-1:0] r;
    r = 8'hff;
    for (int i = MSG_W - 1; i >= 0; i--) begin
      r = {r[CRC_W-2:0], 1'b0} ^ (((r[CRC_W-1] ^ m[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return r;
  endfunction

  // Pin level helpers
  task automatic contacts(input logic an, input logic ac, input logic bn, input logic bc);
    {a_no_o, a_nc_o, b_no_o, b_nc_o} = {an, ac, bn, bc};
  endtask
  task automatic buttons(input logic a, input logic b);
    contacts(a, ~a, b, ~b);
  endtask
  task automatic plant(input logic e, input logic [SECT_N-1:0] dr, input logic [SECT_N-1:0] cm);
    {estop_n_o, door_o, cmd_o} = {e, dr, cm};
  endtask
  task automatic faults(input logic g, input logic i);
    {gnd_o, intf_o} = {g, i};
  endtask

  // Idle levels at time zero
  initial begin
    buttons(1'b0, 1'b0);
    plant(1'b1, '0, '1);
    faults(1'b0, 1'b0);
    {valid_o, data_o, inv_o, crc_o, id_o, stamp_o} = '0;
    permit = 1'b1;
    err_mode = 0;
    gap = 0;
    seq = 8'h00;
  end

  // One message every 16 cycles; lines toggle between messages
  always @(negedge ref_clk_i) begin
    valid_o <= 1'b0;
    gap <= gap + 1;
    {data_o, inv_o, crc_o, id_o, stamp_o} <= ~{data_o, inv_o, crc_o, id_o, stamp_o};
    if (gap >= 15 && err_mode != 5) begin
      gap <= 0;
      seq <= seq + 8'h01;
      d = {7'h00, permit};
      id = (err_mode == 3) ? ~PEER_ID_DEF : PEER_ID_DEF;
      st = (err_mode == 4) ? seq + 8'h02 : seq;
      c = code_of({id, st, d});
      valid_o <= 1'b1;
      data_o <= d;
      inv_o <= (err_mode == 1) ? d : ~d;
      crc_o <= (err_mode == 2) ? ~c : c;
      id_o <= id;
      stamp_o <= st;
    end
  end
endmodule
`default_nettype wire

// ===== tb/thsg_gating_test.sv
// Self-checking bench of the two-hand safety gating core
`timescale 1ns/100ps
`default_nettype none
module thsg_gating_test;
  import thsg_pkg::*;
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: %s", $time, m); end end
  logic                ref_clk;
  logic                reset_n;
  logic                a_no, a_nc, b_no, b_nc, estop_n, gnd, intf, mv;
  logic [SECT_N-1:0]   door, cmd, operate;
  logic [DATA_W-1:0]   md, mi;
  logic [CRC_W-1:0]    mc;
  logic [ID_W-1:0]     mid;
  logic [STAMP_W-1:0]  ms;
  logic                p_load, p_echo_v, two_hand, wiring_fault, param_ok, comm_fault;
  logic [PARAM_W-1:0]  p_word, p_echo;
  int                  n_mismatch = 0;
  int                  checked = 0;

  thsg_gating #(.SYNC_CYCLES(20), .DISC_CYCLES(8), .TMO_CYCLES(64)) u_thsg_gating (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .push_a_no_i(a_no), .push_a_nc_i(a_nc),
    .push_b_no_i(b_no), .push_b_nc_i(b_nc), .estop_n_i(estop_n), .door_open_i(door),
    .operate_cmd_i(cmd), .ground_fault_i(gnd), .internal_fault_i(intf), .param_load_i(p_load),
    .param_word_i(p_word), .param_echo_valid_i(p_echo_v), .param_echo_i(p_echo), .msg_valid_i(mv),
    .msg_data_i(md), .msg_inv_i(mi), .msg_crc_i(mc), .msg_src_id_i(mid), .msg_stamp_i(ms),
    .operate_o(operate), .two_hand_o(two_hand), .wiring_fault_o(wiring_fault),
    .param_ok_o(param_ok), .comm_fault_o(comm_fault));
  thsg_far_side u_thsg_far_side (
    .ref_clk_i(ref_clk), .a_no_o(a_no), .a_nc_o(a_nc), .b_no_o(b_no), .b_nc_o(b_nc),
    .estop_n_o(estop_n), .door_o(door), .cmd_o(cmd), .gnd_o(gnd), .intf_o(intf), .valid_o(mv),
    .data_o(md), .inv_o(mi), .crc_o(mc), .id_o(mid), .stamp_o(ms));

  // Clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic param(input logic l, input logic v, input logic [PARAM_W-1:0] w, input logic [PARAM_W-1:0] e);
    {p_load, p_echo_v, p_word, p_echo} = {l, v, w, e};
    cyc(1);
    {p_load, p_echo_v} = 2'b00;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    u_thsg_far_side.buttons(1'b0, 1'b0);
    u_thsg_far_side.plant(1'b1, 2'b00, 2'b11);
    u_thsg_far_side.faults(1'b0, 1'b0);
    u_thsg_far_side.err_mode = 0;
    u_thsg_far_side.permit = 1'b1;
    cyc(20);
    reset_n = 1'b1;
    cyc(1);
    `CHK({operate, two_hand, wiring_fault, param_ok, comm_fault}, 6'h00, "outputs after reset")
  endtask
  task automatic ready();
    do_reset();
    param(1'b1, 1'b1, 16'h1234, 16'h1234);
    cyc(20);
    `CHK(param_ok, 1'b1, "parameters not confirmed")
  endtask
  task automatic start();
    u_thsg_far_side.buttons(1'b1, 1'b1);
    cyc(6);
    `CHK({two_hand, operate}, 3'b111, "start refused")
  endtask
  task automatic t_param();
    do_reset();
    param(1'b1, 1'b1, 16'h00ff, 16'h00fe);
    cyc(2);
    `CHK(param_ok, 1'b0, "wrong read-back accepted")
    u_thsg_far_side.buttons(1'b1, 1'b1);
    cyc(20);
    `CHK({two_hand, operate}, 3'b100, "operate before confirmation")
    param(1'b0, 1'b1, 16'h0000, 16'h00ff);
    cyc(4);
    `CHK({param_ok, operate}, 3'b111, "confirmation not applied")
    param(1'b1, 1'b0, 16'h0002, 16'h0000);
    cyc(4);
    `CHK({param_ok, operate}, 3'b000, "new load kept confirmation")
    u_thsg_far_side.buttons(1'b0, 1'b0);
    cyc(4);
  endtask
  task automatic t_single();
    u_thsg_far_side.buttons(1'b1, 1'b0);
    cyc(30);
    `CHK(two_hand, 1'b0, "single press started")
    u_thsg_far_side.buttons(1'b1, 1'b1);
    cyc(6);
    `CHK({two_hand, operate}, 3'b000, "late press after expiry")
    u_thsg_far_side.buttons(1'b0, 1'b0);
    cyc(4);
  endtask
  task automatic t_sync();
    for (int i = 0; i < 2; i++) begin
      u_thsg_far_side.buttons(1'b1, 1'b0);
      cyc(10);
      start();
      u_thsg_far_side.buttons(1'b0, i == 0);
      cyc(4);
      `CHK({two_hand, operate}, 3'b000, "release did not drop")
      u_thsg_far_side.buttons(1'b1, 1'b1);
      cyc(6);
      `CHK(two_hand, (i == 1), "restart after partial or full release wrong")
      u_thsg_far_side.buttons(1'b0, 1'b0);
      cyc(4);
    end
  endtask
  task automatic t_late();
    u_thsg_far_side.buttons(1'b0, 1'b1);
    cyc(26);
    u_thsg_far_side.buttons(1'b1, 1'b1);
    cyc(6);
    `CHK(two_hand, 1'b0, "second press outside window")
    u_thsg_far_side.buttons(1'b0, 1'b0);
    cyc(4);
  endtask
  task automatic t_gate();
    start();
    u_thsg_far_side.plant(1'b1, 2'b00, 2'b01);
    cyc(5);
    `CHK(operate, 2'b01, "command not obeyed")
    u_thsg_far_side.plant(1'b1, 2'b01, 2'b11);
    cyc(5);
    `CHK({operate, two_hand}, 3'b101, "door gated wrong section")
    u_thsg_far_side.plant(1'b1, 2'b00, 2'b11);
    u_thsg_far_side.permit = 1'b0;
    cyc(22);
    `CHK(operate, 2'b00, "operate without remote permit")
    u_thsg_far_side.permit = 1'b1;
    cyc(22);
    `CHK({operate, wiring_fault, comm_fault}, 4'b1100, "good traffic faulted")
    u_thsg_far_side.plant(1'b0, 2'b00, 2'b11);
    cyc(5);
    `CHK(operate, 2'b00, "emergency stop ignored")
    u_thsg_far_side.buttons(1'b0, 1'b0);
    cyc(4);
  endtask
  task automatic t_wiring();
    for (int k = 0; k < 3; k++) begin
      ready();
      start();
      if (k == 0) u_thsg_far_side.contacts(1'b1, 1'b1, 1'b1, 1'b0);
      else u_thsg_far_side.faults(k == 1, k == 2);
      cyc(14);
      `CHK({wiring_fault, operate}, 3'b100, "wiring fault missed")
    end
  endtask
  task automatic t_msg();
    for (int k = 1; k < 6; k++) begin
      ready();
      start();
      u_thsg_far_side.err_mode = k;
      cyc(84);
      `CHK({comm_fault, operate}, 3'b100, "bad message accepted")
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog, about ten thousand cycles
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    {p_load, p_echo_v, p_word, p_echo} = '0;
    t_param();
    ready();
    t_single();
    t_sync();
    t_late();
    t_gate();
    t_wiring();
    t_msg();
    tally_and_finish();
  end
endmodule
`default_nettype wire
